// File: common/rtccs_pkg.sv
// Shared constants for the calendar clock control and status logic
package rtccs_pkg;
    // Register addresses on the 4-bit bus
    localparam logic [3:0] ADDR_WEEK = 4'hC;
    localparam logic [3:0] ADDR_CD   = 4'hD;
    localparam logic [3:0] ADDR_CE   = 4'hE;
    localparam logic [3:0] ADDR_CF   = 4'hF;

    // Access control register bits
    localparam int CD_HOLD = 0;
    localparam int CD_BUSY = 1;
    localparam int CD_FLAG = 2;
    localparam int CD_ADJ  = 3;

    // Periodic output control register bits
    localparam int CE_MASK = 0;
    localparam int CE_MODE = 1;
    localparam int CE_PSL  = 2;
    localparam int CE_PSH  = 3;

    // Counter clear control register bits
    localparam int CF_CLR = 0;

    // Reset values
    localparam logic [3:0] CE_RESET   = 4'h1;
    localparam logic       HOLD_RESET = 1'b0;
    localparam logic       CLR_RESET  = 1'b0;

    // Period selects
    localparam logic [1:0] PSEL_TICK = 2'h0;
    localparam logic [1:0] PSEL_SEC  = 2'h1;
    localparam logic [1:0] PSEL_MIN  = 2'h2;
    localparam logic [1:0] PSEL_HOUR = 2'h3;

    // Calendar limits
    localparam logic [2:0] WEEK_LAST  = 3'h6;
    localparam logic [5:0] SEC_LAST   = 6'h3B;
    localparam logic [5:0] SEC_HALF   = 6'h1E;
    localparam logic [5:0] MIN_LAST   = 6'h3B;
    localparam logic [4:0] HOUR_LAST  = 5'h17;
    localparam int         TICKS_PER_SEC = 64;

    // Timing: clock rate and printed durations
    localparam int CLK_MHZ   = 50;
    localparam int TICK_US   = 15625;
    localparam int BUSY_US   = 190;
    localparam int ADJ_US    = 125;
    localparam int PULSE_NS  = 7812500;
    localparam int TICK_CYC  = TICK_US * CLK_MHZ;
    localparam int BUSY_CYC  = BUSY_US * CLK_MHZ;
    localparam int ADJ_CYC   = ADJ_US * CLK_MHZ;
    localparam int PULSE_CYC = PULSE_NS / (1000 / CLK_MHZ);
endpackage : rtccs_pkg

// File: design/rtccs_prescaler.sv
// Sub-second prescaler giving 1/64 second ticks and carries into seconds
`timescale 1ns/1ps
`default_nettype none
module rtccs_prescaler #(
    parameter int TICK_CYC = rtccs_pkg::TICK_CYC
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic clr,
    output logic      tick,
    output logic      sec_carry
);
    logic [19:0] div_r;
    logic [5:0]  sub_r;

    assign tick      = (div_r == 20'(TICK_CYC - 1)) && !clr;
    assign sec_carry = tick && (sub_r == 6'(rtccs_pkg::TICKS_PER_SEC - 1));

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_r <= 20'h00000;
            sub_r <= 6'h00;
        end else if (clk_en) begin
            if (clr) begin
                div_r <= 20'h00000;
                sub_r <= 6'h00;
            end else if (tick) begin
                div_r <= 20'h00000;
                sub_r <= sub_r + 6'h01;
            end else begin
                div_r <= div_r + 20'h00001;
            end
        end
    end
endmodule : rtccs_prescaler
`default_nettype wire

// File: design/rtccs_time_count.sv
// Seconds, minutes, hours and day-of-week counters with carry outputs
`timescale 1ns/1ps
`default_nettype none
module rtccs_time_count (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       clk_en,
    input  wire logic       step,
    input  wire logic       adj_go,
    input  wire logic       week_wr,
    input  wire logic [2:0] week_wdata,
    output logic            min_carry,
    output logic            hour_carry,
    output logic [2:0]      week
);
    logic [5:0] sec_r;
    logic [5:0] min_r;
    logic [4:0] hour_r;
    logic       day_carry;

    // Rounding sends seconds of 30 or more up into the next minute
    assign min_carry  = (step && sec_r == rtccs_pkg::SEC_LAST)
                        || (adj_go && sec_r >= rtccs_pkg::SEC_HALF);
    assign hour_carry = min_carry && min_r == rtccs_pkg::MIN_LAST;
    assign day_carry  = hour_carry && hour_r == rtccs_pkg::HOUR_LAST;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sec_r  <= 6'h00;
            min_r  <= 6'h00;
            hour_r <= 5'h00;
        end else if (clk_en) begin
            if (adj_go || (step && sec_r == rtccs_pkg::SEC_LAST)) begin
                sec_r <= 6'h00;
            end else if (step) begin
                sec_r <= sec_r + 6'h01;
            end
            if (min_carry) begin
                min_r <= (min_r == rtccs_pkg::MIN_LAST) ? 6'h00 : min_r + 6'h01;
            end
            if (hour_carry) begin
                hour_r <= (hour_r == rtccs_pkg::HOUR_LAST) ? 5'h00 : hour_r + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            week <= 3'h0;
        end else if (clk_en) begin
            if (week_wr) begin
                week <= week_wdata;
            end else if (day_carry) begin
                week <= (week >= rtccs_pkg::WEEK_LAST) ? 3'h0 : week + 3'h1;
            end
        end
    end
endmodule : rtccs_time_count
`default_nettype wire

// File: design/rtccs_ctrl.sv
// Control and status logic of the calendar clock: bus, hold, adjust, periodic output
//
// Summary of operation
// - Day of week counts 0 to 6, wraps
// - Granted hold freezes counting from one-second digit up
// - One carry during hold applied on release
// - Chip select high-active low clears hold
// - Busy is 1 without hold, 0 while granted
// - Busy bit is read-only
// - Busy window 190 us each second; host retries
// - Control registers always accessible
// - Flag equals periodic pin driven low
// - Mask 0 lets events pull pin low
// - Interrupt mode latches; new events discarded
// - Waveform low ends on clear or 7.8125 ms
// - Mode bit selects latched request or pulse
// - Period select: 1/64 s, second, minute, hour
// - Adjust rounds seconds; bit self-clears after 125 us
// - Adjust carry low held until ticks resume
// - Time register writes never touch the pin
// - Clear bit holds prescaler; chip select clears
// - Writing 1 to flag keeps it
`timescale 1ns/1ps
`default_nettype none
module rtccs_ctrl #(
    parameter int TICK_CYC  = rtccs_pkg::TICK_CYC,
    parameter int BUSY_CYC  = rtccs_pkg::BUSY_CYC,
    parameter int ADJ_CYC   = rtccs_pkg::ADJ_CYC,
    parameter int PULSE_CYC = rtccs_pkg::PULSE_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       clk_en,
    input  wire logic       chip_select_high_active,
    input  wire logic       sel_n,
    input  wire logic       ale,
    input  wire logic [3:0] addr,
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    input  wire logic [3:0] data_in,
    output logic      [3:0] data_out,
    output logic            data_oe,
    output logic            periodic_pulse_pin_out,
    output logic            periodic_pulse_pin_oe
);
    logic        cs_ok;
    logic [3:0]  addr_r;
    logic [3:0]  eff_addr;
    logic        wr_n_r;
    logic        wr_stb;
    logic        wr_week;
    logic        wr_cd;
    logic        wr_ce;
    logic        wr_cf;
    logic        hold_r;
    logic        hold_nxt;
    logic        grant_r;
    logic        freeze;
    logic        release_hold;
    logic        pend_r;
    logic        busy_rd;
    logic [13:0] busy_cnt_r;
    logic        adj_r;
    logic        adj_go;
    logic [12:0] adj_cnt_r;
    logic [3:0]  ce_r;
    logic        clr_r;
    logic        tick;
    logic        sec_carry;
    logic        step;
    logic        min_carry;
    logic        hour_carry;
    logic [2:0]  week;
    logic        event_hit;
    logic        flag_r;
    logic        flag_set;
    logic        flag_clr;
    logic        flag_nxt;
    logic        auto_end;
    logic        wait_tick_r;
    logic [18:0] pulse_cnt_r;
    logic [3:0]  rd_val;

    // Bus front end: address latch and write strobe on rising write edge
    assign cs_ok    = chip_select_high_active && !sel_n;
    assign eff_addr = ale ? addr : addr_r;
    assign wr_stb   = clk_en && cs_ok && wr_n && !wr_n_r;
    assign wr_week  = wr_stb && eff_addr == rtccs_pkg::ADDR_WEEK;
    assign wr_cd    = wr_stb && eff_addr == rtccs_pkg::ADDR_CD;
    assign wr_ce    = wr_stb && eff_addr == rtccs_pkg::ADDR_CE;
    assign wr_cf    = wr_stb && eff_addr == rtccs_pkg::ADDR_CF;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            addr_r <= 4'h0;
            wr_n_r <= 1'b1;
        end else if (clk_en) begin
            if (cs_ok && ale) begin
                addr_r <= addr;
            end
            wr_n_r <= wr_n || !cs_ok;
        end
    end

    // Hold and grant handshake
    always_comb begin
        hold_nxt = hold_r;
        if (!chip_select_high_active) begin
            hold_nxt = 1'b0;
        end else if (wr_cd) begin
            hold_nxt = data_in[rtccs_pkg::CD_HOLD];
        end
    end

    assign freeze       = hold_r && grant_r;
    assign release_hold = freeze && !hold_nxt;
    assign busy_rd      = !freeze;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hold_r  <= rtccs_pkg::HOLD_RESET;
            grant_r <= 1'b0;
        end else if (clk_en) begin
            hold_r <= hold_nxt;
            if (!hold_nxt) begin
                grant_r <= 1'b0;
            end else if (!hold_r) begin
                grant_r <= (busy_cnt_r == 14'h0000);
            end
        end
    end

    // Carry into seconds: suppressed under granted hold, one carry kept for release
    assign step = (sec_carry && !freeze) || (release_hold && (pend_r || sec_carry));

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pend_r <= 1'b0;
        end else if (clk_en) begin
            if (release_hold || !freeze) begin
                pend_r <= 1'b0;
            end else if (sec_carry) begin
                pend_r <= 1'b1;
            end
        end
    end

    // Busy window following each seconds update
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busy_cnt_r <= 14'h0000;
        end else if (clk_en) begin
            if (sec_carry) begin
                busy_cnt_r <= 14'(BUSY_CYC);
            end else if (busy_cnt_r != 14'h0000) begin
                busy_cnt_r <= busy_cnt_r - 14'h0001;
            end
        end
    end

    // Half-minute rounding with self-clearing status bit
    assign adj_go = wr_cd && data_in[rtccs_pkg::CD_ADJ] && !adj_r;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            adj_r     <= 1'b0;
            adj_cnt_r <= 13'h0000;
        end else if (clk_en) begin
            if (adj_go) begin
                adj_r     <= 1'b1;
                adj_cnt_r <= 13'(ADJ_CYC - 1);
            end else if (adj_cnt_r != 13'h0000) begin
                adj_cnt_r <= adj_cnt_r - 13'h0001;
            end else begin
                adj_r <= 1'b0;
            end
        end
    end

    // Periodic output control and counter clear registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ce_r <= rtccs_pkg::CE_RESET;
        end else if (clk_en && wr_ce) begin
            ce_r <= data_in;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clr_r <= rtccs_pkg::CLR_RESET;
        end else if (clk_en) begin
            if (!chip_select_high_active) begin
                clr_r <= 1'b0;
            end else if (wr_cf) begin
                clr_r <= data_in[rtccs_pkg::CF_CLR];
            end
        end
    end

    rtccs_prescaler #(
        .TICK_CYC (TICK_CYC)
    ) u_prescaler (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .clk_en    (clk_en),
        .clr       (clr_r || adj_r),
        .tick      (tick),
        .sec_carry (sec_carry)
    );

    rtccs_time_count u_time_count (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .clk_en     (clk_en),
        .step       (step),
        .adj_go     (adj_go),
        .week_wr    (wr_week),
        .week_wdata (data_in[2:0]),
        .min_carry  (min_carry),
        .hour_carry (hour_carry),
        .week       (week)
    );

    // Events come only from counter carries; an adjust write can raise one through the minute carry
    always_comb begin
        unique case (ce_r[rtccs_pkg::CE_PSH:rtccs_pkg::CE_PSL])
            rtccs_pkg::PSEL_TICK: event_hit = tick;
            rtccs_pkg::PSEL_SEC:  event_hit = step;
            rtccs_pkg::PSEL_MIN:  event_hit = min_carry;
            rtccs_pkg::PSEL_HOUR: event_hit = hour_carry;
        endcase
    end

    // Flag and pin; a set in the same cycle as a clear wins
    assign flag_set = clk_en && event_hit && !ce_r[rtccs_pkg::CE_MASK]
                      && !(ce_r[rtccs_pkg::CE_MODE] && flag_r);
    assign auto_end = !ce_r[rtccs_pkg::CE_MODE] && flag_r
                      && (wait_tick_r ? tick : pulse_cnt_r == 19'h00001);
    assign flag_clr = (wr_cd && !data_in[rtccs_pkg::CD_FLAG])
                      || ce_r[rtccs_pkg::CE_MASK] || auto_end;
    assign flag_nxt = flag_set ? 1'b1 : (flag_clr ? 1'b0 : flag_r);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flag_r                 <= 1'b0;
            periodic_pulse_pin_oe  <= 1'b0;
            periodic_pulse_pin_out <= 1'b0;
        end else if (clk_en) begin
            flag_r                 <= flag_nxt;
            periodic_pulse_pin_oe  <= flag_nxt;
            periodic_pulse_pin_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pulse_cnt_r <= 19'h00000;
            wait_tick_r <= 1'b0;
        end else if (clk_en) begin
            if (flag_set) begin
                pulse_cnt_r <= 19'(PULSE_CYC);
                wait_tick_r <= adj_go || adj_r;
            end else if (!flag_nxt) begin
                pulse_cnt_r <= 19'h00000;
                wait_tick_r <= 1'b0;
            end else if (pulse_cnt_r > 19'h00001) begin
                pulse_cnt_r <= pulse_cnt_r - 19'h00001;
            end
        end
    end

    // Read path; busy reflects status only, no store behind it
    always_comb begin
        unique case (eff_addr)
            rtccs_pkg::ADDR_WEEK: rd_val = {1'b0, week};
            rtccs_pkg::ADDR_CD:   rd_val = {adj_r, flag_r, busy_rd, hold_r};
            rtccs_pkg::ADDR_CE:   rd_val = ce_r;
            rtccs_pkg::ADDR_CF:   rd_val = {3'h0, clr_r};
            default:              rd_val = 4'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            data_out <= 4'h0;
            data_oe  <= 1'b0;
        end else if (clk_en) begin
            data_out <= rd_val;
            data_oe  <= cs_ok && !rd_n && wr_n;
        end
    end
endmodule : rtccs_ctrl
`default_nettype wire

// File: sim/rtccs_ctrl_sva.sv
// Concurrent checks on the ports of the control and status logic
`timescale 1ns/1ps
`default_nettype none
module rtccs_ctrl_sva #(
    parameter int PULSE_CYC = rtccs_pkg::PULSE_CYC
) (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       clk_en,
    input wire logic       chip_select_high_active,
    input wire logic       sel_n,
    input wire logic       ale,
    input wire logic [3:0] addr,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic [3:0] data_in,
    input wire logic [3:0] data_out,
    input wire logic       data_oe,
    input wire logic       periodic_pulse_pin_out,
    input wire logic       periodic_pulse_pin_oe
);
    logic       cs_ok;
    logic       wr_take;
    logic       clr_take;
    logic       wr_prev_r;
    logic [3:0] ce_r;
    int         low_cnt_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    assign cs_ok = chip_select_high_active && !sel_n;
    assign wr_take = cs_ok && wr_n && !wr_prev_r;
    assign clr_take = wr_take && addr == rtccs_pkg::ADDR_CD && !data_in[rtccs_pkg::CD_FLAG];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) wr_prev_r <= 1'b1;
        else wr_prev_r <= wr_n || !cs_ok;
    end

    // Shadow of the periodic output control register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) ce_r <= rtccs_pkg::CE_RESET;
        else if (wr_take && addr == rtccs_pkg::ADDR_CE) ce_r <= data_in;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) low_cnt_r <= 0;
        else low_cnt_r <= periodic_pulse_pin_oe ? low_cnt_r + 1 : 0;
    end

    sequence s_rd(a);
        cs_ok && !rd_n && wr_n && addr == a ##1 data_oe;
    endsequence

    sequence s_irq_set;
        ce_r[rtccs_pkg::CE_MODE] && !ce_r[rtccs_pkg::CE_MASK] && periodic_pulse_pin_oe;
    endsequence

    a_pin_out_low: assert property (periodic_pulse_pin_out == 1'b0)
        else $error("periodic pin driven high");
    a_flag_pin_tie: assert property (s_rd(rtccs_pkg::ADDR_CD) |->
        data_out[rtccs_pkg::CD_FLAG] == $past(periodic_pulse_pin_oe))
        else $error("flag differs from pin state");
    a_busy_no_hold: assert property (s_rd(rtccs_pkg::ADDR_CD) ##0
        !data_out[rtccs_pkg::CD_HOLD] |-> data_out[rtccs_pkg::CD_BUSY])
        else $error("busy low without hold");
    a_week_top_zero: assert property (s_rd(rtccs_pkg::ADDR_WEEK) |-> !data_out[3])
        else $error("week top bit reads one");
    a_bus_gated: assert property ($rose(data_oe) |-> $past(cs_ok && !rd_n && wr_n))
        else $error("data driven without select");
    a_mask_open: assert property (ce_r[rtccs_pkg::CE_MASK] &&
        $past(ce_r[rtccs_pkg::CE_MASK]) |=> !periodic_pulse_pin_oe)
        else $error("pin low while masked");
    a_pulse_width: assert property (!ce_r[rtccs_pkg::CE_MODE] &&
        !ce_r[rtccs_pkg::CE_PSH] |-> low_cnt_r <= PULSE_CYC)
        else $error("pulse low too long");
    a_irq_latched: assert property (s_irq_set ##1 (!clr_take && !$past(clr_take)
        && $stable(ce_r)) |-> periodic_pulse_pin_oe)
        else $error("latched request dropped");
endmodule : rtccs_ctrl_sva

bind rtccs_ctrl rtccs_ctrl_sva #(.PULSE_CYC(PULSE_CYC)) u_sva (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .chip_select_high_active(chip_select_high_active), .sel_n(sel_n), .ale(ale),
    .addr(addr), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .periodic_pulse_pin_out(periodic_pulse_pin_out),
    .periodic_pulse_pin_oe(periodic_pulse_pin_oe)
);
`default_nettype wire

// File: sim/rtccs_host_model.sv
// Microcomputer model driving the 4-bit register bus
`timescale 1ns/1ps
`default_nettype none
module rtccs_host_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] data_out,
    input  wire logic       data_oe,
    output logic            chip_select_high_active,
    output logic            sel_n,
    output logic            ale,
    output logic [3:0]      addr,
    output logic            wr_n,
    output logic            rd_n,
    output logic [3:0]      data_in
);
    initial begin
        chip_select_high_active = 1'b1;
        sel_n = 1'b0;
        ale = 1'b1;
        addr = 4'h0;
        wr_n = 1'b1;
        rd_n = 1'b1;
        data_in = 4'h0;
    end

    task automatic bus_wr(input logic [3:0] a, input logic [3:0] d);
        @(negedge clk_sys);
        addr = a;
        data_in = d;
        wr_n = 1'b0;
        @(negedge clk_sys);
        wr_n = 1'b1;
        @(negedge clk_sys);
        data_in = ~d;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, output logic [3:0] d);
        @(negedge clk_sys);
        addr = a;
        rd_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        d = (data_oe === 1'b1) ? data_out : 4'hX;
        rd_n = 1'b1;
    endtask : bus_rd

    // Retry hold until granted; flag position written 1 so it is kept
    task automatic take_hold(output logic ok);
        logic [3:0] s;
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            bus_wr(rtccs_pkg::ADDR_CD, 4'h4);
            bus_wr(rtccs_pkg::ADDR_CD, 4'h5);
            bus_rd(rtccs_pkg::ADDR_CD, s);
            ok = (s[rtccs_pkg::CD_BUSY] === 1'b0);
        end
    endtask : take_hold

    task automatic cs_drop;
        @(negedge clk_sys);
        chip_select_high_active = 1'b0;
        repeat (3) @(negedge clk_sys);
        chip_select_high_active = 1'b1;
    endtask : cs_drop
endmodule : rtccs_host_model
`default_nettype wire

// File: sim/rtccs_ctrl_test.sv
// Self-checking testbench of the calendar clock control and status logic
`timescale 1ns/1ps
`default_nettype none
module rtccs_ctrl_test;
    localparam int TICK = 20;
    localparam int PULSE = 6;
    logic       clk_sys = 1'b0;
    logic       nrst = 1'b0;
    logic       cs_hi, sel_n, ale, wr_n, rd_n, data_oe, pin_out, pin_oe;
    logic [3:0] addr, data_in, data_out;
    int         err_count = 0;
    int         cmp_count = 0;
    int         cyc = 0;

    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    rtccs_host_model HOST (
        .clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe),
        .chip_select_high_active(cs_hi), .sel_n(sel_n), .ale(ale), .addr(addr),
        .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in)
    );

    rtccs_ctrl #(.TICK_CYC(TICK), .BUSY_CYC(5), .ADJ_CYC(4), .PULSE_CYC(PULSE)) DUT (
        .clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .chip_select_high_active(cs_hi),
        .sel_n(sel_n), .ale(ale), .addr(addr), .wr_n(wr_n), .rd_n(rd_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .periodic_pulse_pin_out(pin_out), .periodic_pulse_pin_oe(pin_oe)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // Returns the cycle at which the pin first shows lvl, or -1
    task automatic wait_pin(input logic lvl, input int lim, output int t);
        t = -1;
        for (int i = 0; i < lim && t < 0; i++) begin
            @(negedge clk_sys);
            if (pin_oe === lvl) t = cyc;
        end
    endtask : wait_pin

    task automatic t_reset;
        logic [3:0] v;
        logic [3:0] a [5] = '{rtccs_pkg::ADDR_WEEK, rtccs_pkg::ADDR_CD, rtccs_pkg::ADDR_CE,
                              rtccs_pkg::ADDR_CF, 4'h3};
        logic [3:0] e [5] = '{4'h0, 4'h2, rtccs_pkg::CE_RESET, 4'h0, 4'h0};
        for (int i = 0; i < 5; i++) begin
            HOST.bus_rd(a[i], v);
            check("reset value", 16'(v), 16'(e[i]));
        end
    endtask : t_reset

    task automatic t_week;
        logic [3:0] v;
        for (int d = 0; d < 7; d++) begin
            HOST.bus_wr(rtccs_pkg::ADDR_WEEK, 4'h8 | 4'(d));
            HOST.bus_rd(rtccs_pkg::ADDR_WEEK, v);
            check("week", 16'(v), 16'(d));
        end
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'h4);
        HOST.bus_rd(rtccs_pkg::ADDR_CD, v);
        check("busy write", 16'(v), 16'h0002);
    endtask : t_week

    task automatic t_hold;
        logic       ok;
        logic [3:0] v;
        HOST.take_hold(ok);
        check("hold grant", 16'(ok), 16'h0001);
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'h7);
        HOST.bus_wr(rtccs_pkg::ADDR_CF, 4'h1);
        repeat (2600) @(negedge clk_sys);
        HOST.bus_rd(rtccs_pkg::ADDR_CD, v);
        check("held cd", 16'(v), 16'h0001);
        HOST.bus_rd(rtccs_pkg::ADDR_CF, v);
        check("held cf", 16'(v), 16'h0001);
        HOST.cs_drop();
        HOST.bus_rd(rtccs_pkg::ADDR_CD, v);
        check("cd after select", 16'(v), 16'h0002);
        HOST.bus_rd(rtccs_pkg::ADDR_CF, v);
        check("cf after select", 16'(v), 16'h0000);
    endtask : t_hold

    task automatic t_pulse;
        int t0, t1, t2;
        HOST.bus_wr(rtccs_pkg::ADDR_CE, 4'h0);
        wait_pin(1'b1, 2 * TICK, t0);
        wait_pin(1'b0, 2 * TICK, t1);
        wait_pin(1'b1, 2 * TICK, t2);
        check("pulse width", 16'(t1 - t0), 16'(PULSE));
        check("tick period", 16'(t2 - t0), 16'(TICK));
    endtask : t_pulse

    // Clearing first lines the wait up with a fresh tick event
    task automatic t_irq;
        int t;
        HOST.bus_wr(rtccs_pkg::ADDR_CE, 4'h2);
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'h0);
        wait_pin(1'b1, 2 * TICK, t);
        repeat (45) @(negedge clk_sys);
        check("latched", 16'(pin_oe), 16'h0001);
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'h4);
        check("flag kept", 16'(pin_oe), 16'h0001);
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'h0);
        @(negedge clk_sys);
        check("flag cleared", 16'(pin_oe), 16'h0000);
        HOST.bus_wr(rtccs_pkg::ADDR_CE, 4'h3);
        wait_pin(1'b1, 5 * TICK, t);
        check("masked", 16'(t), 16'hFFFF);
    endtask : t_irq

    // Hold set right after a carry falls in the busy window
    task automatic t_second;
        logic       ok;
        logic [3:0] v;
        int         t0, t1;
        HOST.bus_wr(rtccs_pkg::ADDR_CE, 4'h6);
        wait_pin(1'b1, 66 * TICK, t0);
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'h0);
        wait_pin(1'b1, 66 * TICK, t1);
        check("second period", 16'(t1 - t0), 16'(64 * TICK));
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'h5);
        HOST.bus_rd(rtccs_pkg::ADDR_CD, v);
        check("busy window", 16'(v), 16'h0007);
        HOST.take_hold(ok);
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'h1);
        repeat (66 * TICK) @(negedge clk_sys);
        check("frozen seconds", 16'(pin_oe), 16'h0000);
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'h0);
        check("held carry applied", 16'(ok && pin_oe), 16'h0001);
    endtask : t_second

    // Seconds restart at the first adjust; the second one rounds up
    task automatic t_adjust;
        logic [3:0] v;
        int         n, t0, t1;
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'hC);
        HOST.bus_rd(rtccs_pkg::ADDR_CD, v);
        check("adjust set", 16'(v[3]), 16'h0001);
        n = 0;
        while (v[3] !== 1'b0 && n < 10) begin
            HOST.bus_rd(rtccs_pkg::ADDR_CD, v);
            n++;
        end
        check("adjust self clear", 16'(v[3]), 16'h0000);
        HOST.bus_wr(rtccs_pkg::ADDR_CE, 4'h8);
        repeat (32 * 64 * TICK) @(negedge clk_sys);
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'hC);
        wait_pin(1'b1, 4, t0);
        wait_pin(1'b0, 4 * TICK, t1);
        check("adjust carry low", 16'(t0 >= 0 && t1 - t0 > PULSE), 16'h0001);
    endtask : t_adjust

    task automatic t_clear;
        int t;
        HOST.bus_wr(rtccs_pkg::ADDR_CE, 4'h2);
        HOST.bus_wr(rtccs_pkg::ADDR_CF, 4'h1);
        HOST.bus_wr(rtccs_pkg::ADDR_CD, 4'h0);
        wait_pin(1'b1, 5 * TICK, t);
        check("prescaler held", 16'(t), 16'hFFFF);
        HOST.cs_drop();
        wait_pin(1'b1, 2 * TICK, t);
        check("ticks resume", 16'(t >= 0), 16'h0001);
    endtask : t_clear

    initial begin
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        t_reset();
        t_week();
        t_hold();
        t_pulse();
        t_irq();
        t_second();
        t_adjust();
        t_clear();
        test_done();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        err_count++;
        test_done();
    end
endmodule : rtccs_ctrl_test
`default_nettype wire
